// ===== include/bit_exec_map.svh
/*
 * Constants for the bit-oriented file-register executer: field positions,
 * opcodes, sizes and timing counts.
 * Assumes inclusion by bare name from the package and design files.
 */
`ifndef BIT_EXEC_MAP_SVH
`define BIT_EXEC_MAP_SVH

`define INSTR_W          12
`define DATA_W           8
`define ADDR_W           5
`define SEL_W            3
`define OPC_W            4
`define OPC_MSB          11
`define OPC_LSB          8
`define SEL_MSB          7
`define SEL_LSB          5
`define ADDR_MSB         4
`define ADDR_LSB         0
`define FILE_DEPTH       32
`define OPC_BIT_CLEAR    4'h4
`define OPC_BIT_SET      4'h5
`define OPC_BIT_TEST_CLR 4'h6
`define NOP_WORD         12'h000
`define INSTR_CYCLE_NS   10
`define CLK_PERIOD_NS    10
`define SKIP_CYCLES      ((2 * `INSTR_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== include/bit_exec_pkg.sv
/*
 * Types of the bit-oriented file-register executer.
 * Assumes bit_exec_map.svh on the include path.
 */
`include "bit_exec_map.svh"
package bit_exec_pkg;
    typedef enum logic [1:0] {
        exec_state_run,
        exec_state_write,
        exec_state_flush
    } exec_state_type;

    typedef enum logic [1:0] {
        bit_clear_file_op,
        bit_set_file_op,
        bit_test_skip_clear_op,
        other_op
    } op_type;
endpackage

// ===== include/file_port_if.sv
/*
 * Interface between the executer and its file register array.
 * Assumes one clock shared by both sides.
 */
`timescale 1ns/10ps
`include "bit_exec_map.svh"
interface file_port_if;
    logic                  we;
    logic [`ADDR_W-1:0]    waddr;
    logic [`DATA_W-1:0]    wdata;
    logic [`ADDR_W-1:0]    raddr;
    logic [`DATA_W-1:0]    rdata;

    modport owner (input we, input waddr, input wdata, input raddr, output rdata);
    modport user  (output we, output waddr, output wdata, output raddr, input rdata);
endinterface

// ===== src/file_regs.sv
/*
 * Data file register array, 32 bytes, registered read data.
 * Assumes a single clock; write and read in the same cycle return old data.
 */
`timescale 1ns/10ps
`include "bit_exec_map.svh"
module file_regs (
    input  wire logic   sys_clk,
    file_port_if.owner  port
);
    logic [`DATA_W-1:0] mem [`FILE_DEPTH];

    always_ff @(posedge sys_clk) begin
        if (port.we) begin
            mem[port.waddr] <= port.wdata;
        end
        port.rdata <= mem[port.raddr];
    end
endmodule

// ===== src/bit_instr_exec.sv
/*
 * Executer for bit clear, bit set and bit test-skip-if-clear on the data
 * file. Read data is registered, so set/clear read the byte in one cycle and
 * write it back in the next, a cycle in which no new instruction is taken.
 * Assumes instr_valid words arrive no closer than every other cycle for a
 * bit operation, every third after a taken skip (the core honours busy), and that other opcodes are handled
 * elsewhere. A bit op offered while busy is dropped, not held, so the core
 * must offer it again. A test of a byte never written reads unknown and is
 * taken as no skip.
 */
`timescale 1ns/10ps
`include "bit_exec_map.svh"
module bit_instr_exec
    import bit_exec_pkg::*;
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst_b,
    input  wire logic                 instr_valid,
    input  wire logic [`INSTR_W-1:0]  instr_word,
    input  wire logic [`INSTR_W-1:0]  prefetch_word,
    output logic                      busy,
    output logic                      flush_prefetch,
    output logic [`INSTR_W-1:0]       exec_word,
    output logic                      file_written,
    output logic                      status_we,
    output logic [`DATA_W-1:0]        last_result
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic op_type decode_op(input logic [`INSTR_W-1:0] w);
        unique case (w[`OPC_MSB:`OPC_LSB])
            `OPC_BIT_CLEAR:    decode_op = bit_clear_file_op;
            `OPC_BIT_SET:      decode_op = bit_set_file_op;
            `OPC_BIT_TEST_CLR: decode_op = bit_test_skip_clear_op;
            default:           decode_op = other_op;
        endcase
    endfunction

    function automatic logic [`DATA_W-1:0] bit_mask(input logic [`SEL_W-1:0] s);
        bit_mask = `DATA_W'(1) << s;
    endfunction

    function automatic logic [`SEL_W-1:0] bit_sel_of(input logic [`INSTR_W-1:0] w);
        bit_sel_of = w[`SEL_MSB:`SEL_LSB];
    endfunction

    function automatic logic [`ADDR_W-1:0] file_addr_of(input logic [`INSTR_W-1:0] w);
        file_addr_of = w[`ADDR_MSB:`ADDR_LSB];
    endfunction

    // ------------------------------------------------------------
    // file register array
    // ------------------------------------------------------------
    // the array answers one cycle after its address, so the read is
    // launched from the live word rather than the held one
    file_port_if fport ();

    file_regs u_file (
        .sys_clk (sys_clk),
        .port    (fport.owner)
    );

    // ------------------------------------------------------------
    // held instruction and outcome
    // ------------------------------------------------------------
    // fields held from the taken word
    exec_state_type             state;
    exec_state_type             next_state;
    op_type                     op;
    op_type                     next_op;
    logic [`SEL_W-1:0]          sel;
    logic [`SEL_W-1:0]          next_sel;
    logic [`ADDR_W-1:0]         addr;
    logic [`ADDR_W-1:0]         next_addr;
    // next values of the output registers
    logic                       next_busy;
    logic                       next_flush_prefetch;
    logic [`INSTR_W-1:0]        next_exec_word;
    logic                       next_file_written;
    logic                       next_status_we;
    logic [`DATA_W-1:0]         next_last_result;
    logic [`DATA_W-1:0]         new_byte;
    // per-cycle decisions shared by both register groups
    op_type                     in_op;
    logic                       take_op;
    logic                       skip_taken;
    logic                       write_back;

    always_comb begin
        // three decisions per cycle drive both register groups
        in_op      = decode_op(instr_word);
        take_op    = 1'b0;
        skip_taken = 1'b0;
        write_back = 1'b0;
        unique case (state)
            exec_state_run: begin
                // words arriving in write or flush are ignored, not queued
                take_op = instr_valid && (in_op != other_op);
            end
            exec_state_write: begin
                if (op == bit_test_skip_clear_op) begin
                    // an unknown bit falls through as no skip
                    if (!fport.rdata[sel]) begin
                        skip_taken = 1'b1;
                    end
                end else begin
                    write_back = 1'b1;
                end
            end
            exec_state_flush: begin
                take_op = 1'b0;
            end
            default: begin
                // unused code, nothing is taken
                take_op = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // read-modify-write
    // ------------------------------------------------------------
    always_comb begin
        // a test forms this byte too, but never writes it
        if (op == bit_set_file_op) begin
            new_byte = fport.rdata | bit_mask(sel);
        end else begin
            new_byte = fport.rdata & ~bit_mask(sel);
        end
    end

    always_comb begin
        // write-back uses the held address; the read must follow the live
        // word so the byte is ready in the write cycle
        fport.raddr = file_addr_of(instr_word);
        fport.waddr = addr;
        fport.we    = write_back;
        fport.wdata = new_byte;
    end

    // ------------------------------------------------------------
    // control state
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_op    = op;
        next_sel   = sel;
        next_addr  = addr;
        unique case (state)
            exec_state_run: begin
                if (take_op) begin
                    next_op    = in_op;
                    next_sel   = bit_sel_of(instr_word);
                    next_addr  = file_addr_of(instr_word);
                    next_state = exec_state_write;
                end
            end
            exec_state_write: begin
                // a taken skip spends one more cycle on the nop
                next_state = skip_taken ? exec_state_flush : exec_state_run;
            end
            exec_state_flush: begin
                // the nop occupies this cycle; new words are ignored
                next_state = exec_state_run;
            end
            default: begin
                // recover from an unused code
                next_state = exec_state_run;
            end
        endcase
    end

    // op, bit and address are held until the write-back cycle
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state <= exec_state_run;
            op    <= other_op;
            sel   <= '0;
            addr  <= '0;
        end else begin
            state <= next_state;
            op    <= next_op;
            sel   <= next_sel;
            addr  <= next_addr;
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    always_comb begin
        // busy covers the write cycle and, on a skip, the nop cycle
        next_busy           = take_op || skip_taken;
        next_flush_prefetch = skip_taken;
        // prefetched word replaced by a nop when the skip is taken
        next_exec_word      = skip_taken ? `NOP_WORD : prefetch_word;
        next_file_written   = write_back;
        // last_result holds between writes
        next_last_result    = write_back ? new_byte : last_result;
        // bit operations never touch arithmetic flags
        next_status_we      = 1'b0;
    end

    // reset shows a nop to the core until the first word
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            busy           <= 1'b0;
            flush_prefetch <= 1'b0;
            exec_word      <= `NOP_WORD;
            file_written   <= 1'b0;
            last_result    <= '0;
            status_we      <= 1'b0;
        end else begin
            busy           <= next_busy;
            flush_prefetch <= next_flush_prefetch;
            exec_word      <= next_exec_word;
            file_written   <= next_file_written;
            last_result    <= next_last_result;
            status_we      <= next_status_we;
        end
    end
endmodule

// ===== verif/bit_instr_exec_chk.sv
/* checker for bit_instr_exec ports
   assumes bit_exec_map.svh on the include path */
`timescale 1ns/10ps
`include "bit_exec_map.svh"
module bit_instr_exec_chk (
    input wire logic                sys_clk,
    input wire logic                rst_b,
    input wire logic                instr_valid,
    input wire logic [`INSTR_W-1:0] instr_word,
    input wire logic [`INSTR_W-1:0] prefetch_word,
    input wire logic                busy,
    input wire logic                flush_prefetch,
    input wire logic [`INSTR_W-1:0] exec_word,
    input wire logic                file_written,
    input wire logic                status_we,
    input wire logic [`DATA_W-1:0]  last_result
);
    wire logic [3:0] opc = instr_word[`OPC_MSB:`OPC_LSB];
    wire logic [2:0] sel = instr_word[`SEL_MSB:`SEL_LSB];
    wire logic       idle_req = instr_valid && !busy;
    wire logic       t_clr = idle_req && opc == `OPC_BIT_CLEAR;
    wire logic       t_set = idle_req && opc == `OPC_BIT_SET;
    wire logic       t_tst = idle_req && opc == `OPC_BIT_TEST_CLR;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    AST_SET_BIT: assert property (t_set |=> busy ##1 (file_written && !busy
        && last_result[$past(sel, 2)])) else $error("set bit missing");
    AST_CLR_BIT: assert property (t_clr |=> busy ##1 (file_written && !busy
        && !last_result[$past(sel, 2)])) else $error("clear bit missing");
    AST_WRITE_CAUSE: assert property (file_written |->
        $past(t_set, 2) || $past(t_clr, 2)) else $error("stray write");
    AST_FLUSH_CAUSE: assert property (flush_prefetch |->
        $past(t_tst, 2)) else $error("stray flush");
    AST_TEST_TWO: assert property (t_tst |=> busy ##1
        (!file_written && busy == flush_prefetch)) else $error("test timing");
    AST_FLUSH_NOP: assert property (flush_prefetch |->
        exec_word == `NOP_WORD ##1 !busy) else $error("flush without nop");
    AST_PASS: assert property (!flush_prefetch && $past(rst_b) |->
        exec_word == $past(prefetch_word)) else $error("next word lost");
    AST_NO_STATUS: assert property (status_we == 1'b0)
        else $error("status written");
endmodule
bind bit_instr_exec bit_instr_exec_chk u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
    .instr_valid(instr_valid), .instr_word(instr_word), .prefetch_word(prefetch_word),
    .busy(busy), .flush_prefetch(flush_prefetch), .exec_word(exec_word),
    .file_written(file_written), .status_we(status_we), .last_result(last_result));

// ===== verif/fetch_model.sv
/* core fetch stand-in giving the word behind the current one
   assumes the executer's clock and reset */
`timescale 1ns/10ps
`include "bit_exec_map.svh"
module fetch_model (
    input  wire logic                sys_clk,
    input  wire logic                rst_b,
    output logic [`INSTR_W-1:0]      prefetch_word
);
    // new word each cycle, so a stale exec_word shows
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            prefetch_word <= 12'h1A5;
        end else begin
            prefetch_word <= prefetch_word + 12'h0C3;
        end
    end
endmodule

// ===== verif/bit_instr_exec_tb.sv
/* testbench for bit_instr_exec with fetch_model
   assumes design files and checker compiled first */
`timescale 1ns/10ps
`include "bit_exec_map.svh"
module bit_instr_exec_tb;
    logic                sys_clk, rst_b, instr_valid, busy, flush_prefetch;
    logic                file_written, status_we;
    logic [`INSTR_W-1:0] instr_word, prefetch_word, exec_word;
    logic [`DATA_W-1:0]  last_result;
    int                  n_fail, samples_checked;
    bit_instr_exec u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .instr_valid(instr_valid),
        .instr_word(instr_word), .prefetch_word(prefetch_word), .busy(busy),
        .flush_prefetch(flush_prefetch), .exec_word(exec_word),
        .file_written(file_written), .status_we(status_we), .last_result(last_result));
    fetch_model u_fetch (.sys_clk(sys_clk), .rst_b(rst_b), .prefetch_word(prefetch_word));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [11:0] got, input logic [11:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    // ----
    // one word per call; ef: skip expected, kr: byte known
    // ----
    task automatic op(input logic [11:0] w, input logic ef, input logic kr,
                      input logic [7:0] er);
        instr_valid = 1'b1;
        instr_word = w;
        @(posedge sys_clk);
        #1;
        instr_valid = 1'b0;
        check(12'(busy), 12'(w[11:8] inside {4'h4, 4'h5, 4'h6}));
        @(posedge sys_clk);
        #1;
        check(12'(file_written), 12'(w[11:9] == 3'h2));
        check(12'(status_we), 12'h000);
        check(12'(flush_prefetch), 12'(ef));
        if (kr) check(12'(last_result), 12'(er));
        if (ef) begin
            check(exec_word, `NOP_WORD);
            @(posedge sys_clk);
            #1;
        end
        check(12'(busy), 12'h000);
    endtask
    task automatic scen_set_clear;
        // array starts undefined, so each byte is known only after all eight of its clears
        for (int i = 0; i < 16; i++) begin
            op({4'h4, 3'(i), i[3] ? 5'h1F : 5'h00}, 1'b0, i[2:0] == 3'h7, 8'h00);
        end
        op(12'h5FF, 1'b0, 1'b1, 8'h80);
        op(12'h51F, 1'b0, 1'b1, 8'h81);
        op(12'h4FF, 1'b0, 1'b1, 8'h01);
    endtask
    task automatic scen_skip;
        op(12'h61F, 1'b0, 1'b0, 8'h00);
        op(12'h6FF, 1'b1, 1'b0, 8'h00);
        op(12'h660, 1'b1, 1'b0, 8'h00);
    endtask
    task automatic scen_refuse;
        op(12'h7FF, 1'b0, 1'b0, 8'h00);
        check(12'(last_result), 12'h001);
    endtask
    // ----
    // valid held through the busy cycle with a second word, then a reset in mid-run
    // ----
    task automatic scen_busy_reset;
        instr_valid = 1'b1;
        instr_word = 12'h53F;
        @(posedge sys_clk);
        #1;
        // a second bit op in the busy cycle must be ignored
        instr_word = 12'h5DF;
        @(posedge sys_clk);
        #1;
        instr_valid = 1'b0;
        check(12'(busy), 12'h000);
        check(12'(file_written), 12'h001);
        check(12'(last_result), 12'h003);
        @(posedge sys_clk);
        #1;
        check(12'(busy), 12'h000);
        check(12'(file_written), 12'h000);
        rst_b = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        check(12'(last_result), 12'h000);
        check(exec_word, `NOP_WORD);
        op(12'h43F, 1'b0, 1'b1, 8'h01);
    endtask
    task automatic give_verdict;
        if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        n_fail = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        instr_valid = 1'b0;
        instr_word = `NOP_WORD;
        repeat (2) @(posedge sys_clk);
        #1;
        rst_b = 1'b1;
        check(exec_word, `NOP_WORD);
        scen_set_clear();
        scen_skip();
        scen_refuse();
        scen_busy_reset();
        give_verdict();
    end
endmodule
